/* File: verilog/iepr_regs.vh */
/*
 Constants for the interrupt enable and priority register bank:
 register addresses, reset values, fixed read bits, source count and index width.
 Assumes it is included by bare name from the design files.
*/
// What this block does
// - Priority register top two bits read one
// - Bits 5,4 set Timer 2, UART level
// - Bits 3-0 set Timer1, pin1, Timer0, pin0 level
// - Enable A bits 7-4 gate comparator edges
// - Enable A bits 3-0 gate PCA, window, SMBus, SPI
// - Enable B bit 7 gates crystal ok
// - Enable B bit 6 reserved, reads zero
// - Enable B bits 5-2 gate pins 7-4
// - Enable B bits 1,0 gate ADC done, Timer3
// - Level A bits 7-4 set comparator levels
// - Level A bits 3-0 set PCA..SPI levels
// - Global gate clear blocks every source
// - High preempts low, high never preempted
// - Higher level wins, then fixed source order
// - Masked requests decoded every clock cycle
`ifndef IEPR_REGS_VH
`define IEPR_REGS_VH

// Register addresses on the special function register port
`define IEPR_ADDR_CORE_PRIO 8'hb8
`define IEPR_ADDR_ENABLE_A 8'he6
`define IEPR_ADDR_ENABLE_B 8'he7
`define IEPR_ADDR_LEVEL_A 8'hf6

// Reset values
`define IEPR_RST_CORE_PRIO 6'h00
`define IEPR_RST_ENABLE_A 8'h00
`define IEPR_RST_ENABLE_B 8'h00
`define IEPR_RST_LEVEL_A 8'h00

// Fixed read values
`define IEPR_CORE_PRIO_TOP 2'h3
`define IEPR_RESERVED_BIT 6
`define IEPR_UNMAPPED_READ 8'h00

// Source count and index width
`define IEPR_NUM_SRC 22
`define IEPR_IDX_W 5
`define IEPR_CORE_SRC 6

`endif

/* File: verilog/iepr_prio_enc.v */
/*
 Fixed order priority encoder: lowest numbered active request wins.
 Assumes a purely combinational use inside the interrupt bank.
*/
`timescale 1ns/100ps
module iepr_prio_enc
#(
	parameter N = 22,
	parameter W = 5
)
(
	// Request vector
	input wire [N-1:0] req_in,
	// Result
	output reg any_out,
	output reg [W-1:0] idx_out
);

	integer i; // Scan index

	// Scan from the top down so the lowest index is the last one kept
	always @*
	begin
		any_out = 1'b0;
		idx_out = {W{1'b0}};
		for (i = N - 1; i >= 0; i = i - 1)
		begin
			if (req_in[i])
			begin
				any_out = 1'b1;
				idx_out = i[W-1:0];
			end
		end
	end

endmodule // iepr_prio_enc

/* File: verilog/iepr_bank.v */
/*
 Interrupt enable and priority register bank with level arbitration.
 Holds the basic priority register, two extended enable registers and
 the first extended priority register, masks the pending flags and
 offers the winning source to the core.
 Assumes pending flags, the global gate, the core enables and the
 second priority byte come from logic on the same clock, and that the
 core pulses an accept when it takes the offered vector and a return
 pulse when a service routine ends.
*/
`timescale 1ns/100ps
`include "iepr_regs.vh"
module iepr_bank
#(
	parameter NSRC = `IEPR_NUM_SRC,
	parameter IW = `IEPR_IDX_W
)
(
	// Clock and reset
	input wire clk_in,
	input wire nrst_in,
	// Special function register port
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_in,
	input wire [7:0] sfr_wdata_in,
	output wire sfr_sel_out,
	output reg [7:0] sfr_rdata_out,
	// Gates and levels held outside this bank
	input wire global_irq_gate_in,
	input wire [5:0] core_irq_enable_in,
	input wire [7:0] periph_irq_level_b_in,
	// Peripheral pending flags, vector order
	input wire [NSRC-1:0] irq_pend_in,
	// Core handshake
	input wire irq_accept_in,
	input wire irq_return_in,
	output reg irq_req_out,
	output reg [IW-1:0] irq_vec_out,
	output reg irq_high_out,
	output reg [NSRC-1:0] irq_masked_out,
	output reg [1:0] irq_active_out
);

	// Software visible registers
	reg [5:0] core_irq_priority; // Low six bits only
	reg [7:0] periph_irq_enable_a; // Comparator and serial masks
	reg [7:0] periph_irq_enable_b; // Bit 6 held at zero
	reg [7:0] periph_irq_level_a; // Comparator and serial levels

	// Service state: bit 1 high routine, bit 0 low routine
	reg active_high;
	reg active_low;

	// Decode results
	wire [NSRC-1:0] src_mask; // Per source enable
	wire [NSRC-1:0] src_level; // Per source high level
	wire [NSRC-1:0] masked; // Enabled pending requests
	wire [NSRC-1:0] hi_req; // Enabled high level requests
	wire [NSRC-1:0] lo_req; // Enabled low level requests
	wire hi_any;
	wire lo_any;
	wire [IW-1:0] hi_idx;
	wire [IW-1:0] lo_idx;
	reg next_req; // Offer for the next cycle
	reg [IW-1:0] next_vec;
	reg next_high;
	reg [7:0] next_rdata;
	wire offer_taken; // Core takes the standing offer this cycle

	// Address match helper used by the port select only
	function is_mapped;
		input [7:0] addr;
		begin
			is_mapped = (addr == `IEPR_ADDR_CORE_PRIO) ||
				(addr == `IEPR_ADDR_ENABLE_A) ||
				(addr == `IEPR_ADDR_ENABLE_B) ||
				(addr == `IEPR_ADDR_LEVEL_A);
		end
	endfunction

	// Write strobe for one address
	function wr_hit;
		input wr;
		input [7:0] addr;
		input [7:0] target;
		begin
			wr_hit = wr && (addr == target);
		end
	endfunction

	// Port select is combinational so the core sees a claim at once
	assign sfr_sel_out = is_mapped(sfr_addr_in);

	// Register writes; new values steer masking from the next cycle
	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			core_irq_priority <= `IEPR_RST_CORE_PRIO;
			periph_irq_enable_a <= `IEPR_RST_ENABLE_A;
			periph_irq_enable_b <= `IEPR_RST_ENABLE_B;
			periph_irq_level_a <= `IEPR_RST_LEVEL_A;
		end
		else
		begin
			// Top two written bits are dropped
			if (wr_hit(sfr_wr_in, sfr_addr_in, `IEPR_ADDR_CORE_PRIO))
				core_irq_priority <= sfr_wdata_in[5:0];
			if (wr_hit(sfr_wr_in, sfr_addr_in, `IEPR_ADDR_ENABLE_A))
				periph_irq_enable_a <= sfr_wdata_in;
			// Reserved bit never stores a one
			if (wr_hit(sfr_wr_in, sfr_addr_in, `IEPR_ADDR_ENABLE_B))
			begin
				periph_irq_enable_b <= sfr_wdata_in &
					~(8'h01 << `IEPR_RESERVED_BIT);
			end
			if (wr_hit(sfr_wr_in, sfr_addr_in, `IEPR_ADDR_LEVEL_A))
				periph_irq_level_a <= sfr_wdata_in;
		end
	end

	// Read data mux, registered
	always @*
	begin
		case (sfr_addr_in)
			`IEPR_ADDR_CORE_PRIO:
				next_rdata = {`IEPR_CORE_PRIO_TOP, core_irq_priority};
			`IEPR_ADDR_ENABLE_A:
				next_rdata = periph_irq_enable_a;
			`IEPR_ADDR_ENABLE_B:
				next_rdata = periph_irq_enable_b;
			`IEPR_ADDR_LEVEL_A:
				next_rdata = periph_irq_level_a;
			default:
				next_rdata = `IEPR_UNMAPPED_READ;
		endcase
	end

	always @(posedge clk_in)
	begin
		if (!nrst_in)
			sfr_rdata_out <= `IEPR_UNMAPPED_READ;
		else
			sfr_rdata_out <= next_rdata;
	end

	// Enables in vector order: core six, enable A, enable B
	// Enable A: 0 SPI, 1 SMBus, 2 window, 3 PCA, 4-7 comparator edges
	// Enable B: 0 Timer3, 1 ADC done, 2-5 pins 4-7, 6 none, 7 crystal
	assign src_mask = {periph_irq_enable_b, periph_irq_enable_a,
		core_irq_enable_in};

	// Levels in vector order; core six follow the priority bit order
	assign src_level = {periph_irq_level_b_in, periph_irq_level_a,
		core_irq_priority};

	// Global gate overrides every individual mask
	assign masked = irq_pend_in & src_mask &
		{NSRC{global_irq_gate_in}};
	assign hi_req = masked & src_level;
	assign lo_req = masked & ~src_level;

	// Fixed order encoders, one per level
	iepr_prio_enc #(
		.N(NSRC),
		.W(IW)
	) u_hi_enc (
		.req_in(hi_req),
		.any_out(hi_any),
		.idx_out(hi_idx)
	);

	iepr_prio_enc #(
		.N(NSRC),
		.W(IW)
	) u_lo_enc (
		.req_in(lo_req),
		.any_out(lo_any),
		.idx_out(lo_idx)
	);

	// An offer counts as taken only while it stands
	assign offer_taken = irq_accept_in && irq_req_out;

	// Pick the offer allowed by the routine now in service
	always @*
	begin
		next_req = 1'b0;
		next_vec = {IW{1'b0}};
		next_high = 1'b0;
		if (active_high || offer_taken)
		begin
			// High routine runs to its end untouched; a taken offer
			// is withdrawn at once so it cannot be taken twice
			next_req = 1'b0;
		end
		else if (hi_any)
		begin
			// High level beats low, also during a low routine
			next_req = 1'b1;
			next_vec = hi_idx;
			next_high = 1'b1;
		end
		else if (lo_any && !active_low)
		begin
			// Low offered only when nothing is in service
			next_req = 1'b1;
			next_vec = lo_idx;
		end
	end

	// Offer is resampled on every clock
	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			irq_req_out <= 1'b0;
			irq_vec_out <= {IW{1'b0}};
			irq_high_out <= 1'b0;
			irq_masked_out <= {NSRC{1'b0}};
		end
		else
		begin
			irq_req_out <= next_req;
			irq_vec_out <= next_vec;
			irq_high_out <= next_high;
			irq_masked_out <= masked;
		end
	end

	// Service tracking; an accept in the return cycle wins
	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			active_high <= 1'b0;
			active_low <= 1'b0;
		end
		else
		begin
			if (irq_return_in)
			begin
				// Innermost routine ends first
				if (active_high)
					active_high <= 1'b0;
				else
					active_low <= 1'b0;
			end
			if (offer_taken)
			begin
				if (irq_high_out)
					active_high <= 1'b1;
				else
					active_low <= 1'b1;
			end
		end
	end

	// Expose service state to the core
	always @*
	begin
		irq_active_out = {active_high, active_low};
	end

endmodule // iepr_bank

/* File: verif/iepr_monitor.sv */
/* Port checker of the interrupt bank, one clock domain.
 Assumes it is bound onto iepr_bank and sees only its ports. */
`timescale 1ns/100ps
module iepr_monitor
#(
	parameter NSRC = 22,
	parameter IW = 5
)
(
	// Clock, reset, register port
	input wire clk_in,
	input wire nrst_in,
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_in,
	input wire [7:0] sfr_wdata_in,
	input wire sfr_sel_out,
	input wire [7:0] sfr_rdata_out,
	// Sources and core side
	input wire global_irq_gate_in,
	input wire [5:0] core_irq_enable_in,
	input wire [7:0] periph_irq_level_b_in,
	input wire [NSRC-1:0] irq_pend_in,
	input wire irq_accept_in,
	input wire irq_return_in,
	input wire irq_req_out,
	input wire [IW-1:0] irq_vec_out,
	input wire irq_high_out,
	input wire [NSRC-1:0] irq_masked_out,
	input wire [1:0] irq_active_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	a_prio_top: assert property (sfr_addr_in == 8'hb8 |=>
		sfr_rdata_out[7:6] == 2'h3) else $error("top bits");
	a_resv_zero: assert property (sfr_addr_in == 8'he7 |=>
		!sfr_rdata_out[6]) else $error("reserved bit");
	a_write_seen: assert property (sfr_wr_in && sfr_addr_in == 8'he6
		##1 !sfr_wr_in && sfr_addr_in == 8'he6 |=>
		sfr_rdata_out == $past(sfr_wdata_in, 2)) else $error("write lost");
	a_gate_block: assert property (!global_irq_gate_in |=>
		irq_masked_out == 0 && !irq_req_out) else $error("gate");
	a_core_mask: assert property ($past(nrst_in) |->
		irq_masked_out[5:0] == ($past(irq_pend_in[5:0] & core_irq_enable_in)
		& {6{$past(global_irq_gate_in)}})) else $error("core mask");
	a_high_hold: assert property (irq_active_out[1] |->
		!irq_req_out) else $error("preempt");
	a_low_preempt: assert property (irq_active_out[0] &&
		irq_req_out |-> irq_high_out) else $error("low offer");
	a_vec_pending: assert property (irq_req_out |->
		irq_masked_out[irq_vec_out]) else $error("vector");
endmodule // iepr_monitor
bind iepr_bank iepr_monitor #(.NSRC(NSRC), .IW(IW)) iepr_monitor_i (.*);

/* File: verif/iepr_core_model.sv */
/* Core stand-in: raises accept DELAY+1 cycles after an offer appears, relays returns.
 Assumes the bank's clock and reset. */
`timescale 1ns/100ps
module iepr_core_model
#(
	parameter DELAY = 2
)
(
	// Clock, reset, bench control
	input wire clk_in,
	input wire nrst_in,
	input wire go_in,
	input wire ret_in,
	// Bank side
	input wire req_in,
	output reg accept_out,
	output reg return_out
);
	reg [3:0] wait_cnt; // Cycles the offer has stood
	// One accept pulse once an offer has stood long enough
	always @(posedge clk_in)
	begin
		accept_out <= 1'b0;
		return_out <= ret_in;
		if (!nrst_in || !go_in || !req_in || accept_out)
			wait_cnt <= 4'h0;
		else if (wait_cnt == DELAY)
			accept_out <= 1'b1;
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule // iepr_core_model

/* File: verif/iepr_bank_bench.sv */
/* Self-checking bench of the interrupt bank with a core stand-in.
 Assumes bank, header and stand-in are compiled first. */
`timescale 1ns/100ps
module iepr_bank_bench;
	reg clk_in = 1'b0, nrst_in = 1'b0, sfr_wr_in = 1'b0, go = 1'b0, ret = 1'b0;
	reg global_irq_gate_in = 1'b0;
	reg [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00;
	reg [7:0] periph_irq_level_b_in = 8'h00;
	reg [5:0] core_irq_enable_in = 6'h00;
	reg [21:0] irq_pend_in = 22'h000000;
	wire sfr_sel_out, irq_accept_in, irq_return_in, irq_req_out, irq_high_out;
	wire [7:0] sfr_rdata_out;
	wire [4:0] irq_vec_out;
	wire [21:0] irq_masked_out;
	wire [1:0] irq_active_out;
	integer failures = 0, cmp_count = 0, i;
	iepr_bank iepr_bank_i (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.sfr_addr_in(sfr_addr_in),
		.sfr_wr_in(sfr_wr_in),
		.sfr_wdata_in(sfr_wdata_in),
		.sfr_sel_out(sfr_sel_out),
		.sfr_rdata_out(sfr_rdata_out),
		.global_irq_gate_in(global_irq_gate_in),
		.core_irq_enable_in(core_irq_enable_in),
		.periph_irq_level_b_in(periph_irq_level_b_in),
		.irq_pend_in(irq_pend_in),
		.irq_accept_in(irq_accept_in),
		.irq_return_in(irq_return_in),
		.irq_req_out(irq_req_out),
		.irq_vec_out(irq_vec_out),
		.irq_high_out(irq_high_out),
		.irq_masked_out(irq_masked_out),
		.irq_active_out(irq_active_out)
	);
	iepr_core_model iepr_core_model_i (.clk_in(clk_in), .nrst_in(nrst_in),
		.go_in(go), .ret_in(ret), .req_in(irq_req_out),
		.accept_out(irq_accept_in), .return_out(irq_return_in));
	initial forever #5 clk_in = ~clk_in;
	task tick(input integer n);
	begin
		repeat (n) @(posedge clk_in);
		#1;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	end
	endtask
	task wreg(input [7:0] a, input [7:0] d);
	begin
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1'b1;
		@(posedge clk_in);
		sfr_wr_in <= 1'b0;
	end
	endtask
	task rreg(input [7:0] a, input [7:0] e);
	begin
		@(posedge clk_in);
		sfr_addr_in <= a;
		tick(1);
		chk(sfr_rdata_out, e);
	end
	endtask
	// Wait a bounded time for the service state
	task wact(input [1:0] e);
		integer n;
	begin
		for (n = 0; n < 20 && irq_active_out !== e; n = n + 1)
			tick(1);
		chk(irq_active_out, e);
	end
	endtask
	task t_regs;
	begin
		rreg(8'hb8, 8'hc0);
		chk(sfr_sel_out, 1'b1);
		rreg(8'he7, 8'h00);
		chk(sfr_sel_out, 1'b1);
		rreg(8'h42, 8'h00);
		chk(sfr_sel_out, 1'b0);
		wreg(8'hb8, 8'hff);
		wreg(8'he6, 8'hff);
		wreg(8'he7, 8'hbf);
		wreg(8'hf6, 8'h3c);
		rreg(8'hb8, 8'hff);
		wreg(8'hb8, 8'h15);
		rreg(8'hb8, 8'hd5);
		rreg(8'he6, 8'hff);
		rreg(8'he7, 8'hbf);
		rreg(8'hf6, 8'h3c);
		chk(sfr_sel_out, 1'b1);
		$display("regs done");
	end
	endtask
	task t_mask;
	begin
		@(posedge clk_in);
		irq_pend_in <= 22'h3fffff;
		global_irq_gate_in <= 1'b1;
		core_irq_enable_in <= 6'h2a;
		tick(2);
		chk(irq_masked_out, {8'hbf, 8'hff, 6'h2a});
		chk({irq_high_out, irq_vec_out}, 6'h28);
		wreg(8'he6, 8'h5a);
		wreg(8'he7, 8'ha5);
		tick(1);
		chk(irq_masked_out, {8'ha5, 8'h5a, 6'h2a});
		@(posedge clk_in);
		global_irq_gate_in <= 1'b0;
		tick(2);
		chk(irq_masked_out, 22'h000000);
		$display("mask done");
	end
	endtask
	task t_level;
	begin
		@(posedge clk_in);
		global_irq_gate_in <= 1'b1;
		core_irq_enable_in <= 6'h3f;
		wreg(8'he6, 8'hff);
		wreg(8'he7, 8'hbf);
		for (i = 0; i < 22; i = i + 1)
		begin
			wreg(8'hb8, (i < 6) ? 8'h01 << i : 8'h00);
			wreg(8'hf6, (i > 5 && i < 14) ? 8'h01 << (i - 6) : 8'h00);
			@(posedge clk_in);
			periph_irq_level_b_in <= (i > 13) ? 8'h01 << (i - 14) : 8'h00;
			tick(2);
			chk({irq_high_out, irq_vec_out},
				(i == 20) ? 6'h00 : {1'b1, i[4:0]});
		end
		$display("level done");
	end
	endtask
	task retn;
	begin
		@(posedge clk_in);
		ret <= 1'b1;
		@(posedge clk_in);
		ret <= 1'b0;
	end
	endtask
	task t_preempt;
	begin
		wreg(8'hf6, 8'h08);
		@(posedge clk_in);
		periph_irq_level_b_in <= 8'h00;
		irq_pend_in <= 22'h000002;
		@(posedge clk_in);
		go <= 1'b1;
		wact(2'h1);
		@(posedge clk_in);
		irq_pend_in <= 22'h000200;
		wact(2'h3);
		chk(irq_req_out, 1'b0);
		@(posedge clk_in);
		irq_pend_in <= 22'h000008;
		tick(4);
		chk(irq_req_out, 1'b0);
		retn;
		wact(2'h1);
		tick(3);
		chk(irq_req_out, 1'b0);
		@(posedge clk_in);
		go <= 1'b0;
		retn;
		wact(2'h0);
		tick(1);
		chk({irq_req_out, irq_high_out, irq_vec_out}, 7'h43);
		$display("preempt done");
	end
	endtask
	task wrap_up;
	begin
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (8) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_regs;
		t_mask;
		t_level;
		t_preempt;
		wrap_up;
	end
	initial
	begin
		#100000;
		failures = failures + 1;
		wrap_up;
	end
endmodule // iepr_bank_bench
